// ==== rtl/spt_pkg.sv ====
package spt_pkg;
	// parameter offsets
	localparam logic [7:0] OFS_NEW_BUS_ADDRESS  = 8'h00;
	localparam logic [7:0] OFS_CHANNEL_ENABLE   = 8'h01;
	localparam logic [7:0] OFS_LED_SEL_CH1_CH2  = 8'h02;
	localparam logic [7:0] OFS_LED_SEL_CH3      = 8'h03;
	localparam logic [7:0] OFS_PROX_ALIGNMENT   = 8'h05;
	localparam logic [7:0] OFS_AMB_HISTORY      = 8'h19;
	localparam logic [7:0] OFS_CONV_OFFSET      = 8'h1A;
	localparam logic [7:0] OFS_RESERVED_1B      = 8'h1B;
	localparam logic [7:0] OFS_LED_RECOVERY     = 8'h1C;
	localparam logic [7:0] OFS_IR_CONV_COUNTER  = 8'h1D;
	localparam logic [7:0] OFS_IR_CONV_GAIN     = 8'h1E;
	localparam logic [7:0] OFS_IR_CONV_MISC     = 8'h1F;

	// reset values
	localparam logic [7:0] RST_NEW_BUS_ADDRESS  = 8'h00;
	localparam logic [7:0] RST_CHANNEL_ENABLE   = 8'h00;
	localparam logic [7:0] RST_LED_SEL_CH1_CH2  = 8'h21;
	localparam logic [7:0] RST_LED_SEL_CH3      = 8'h04;
	localparam logic [7:0] RST_PROX_ALIGNMENT   = 8'h00;
	localparam logic [7:0] RST_OTHER            = 8'h00;
	localparam logic [6:0] RST_BUS_ADDRESS      = 7'h5A;

	// writable-bit masks, reserved bits read as zero
	localparam logic [7:0] MSK_CHANNEL_ENABLE   = 8'h77;
	localparam logic [7:0] MSK_LED_SEL_CH1_CH2  = 8'h77;
	localparam logic [7:0] MSK_LED_SEL_CH3      = 8'h07;
	localparam logic [7:0] MSK_PROX_ALIGNMENT   = 8'h70;
	localparam logic [7:0] MSK_IR_CONV_COUNTER  = 8'h70;
	localparam logic [7:0] MSK_FULL             = 8'hFF;

	// field positions
	localparam int POS_PROX_ONE_ON     = 0;
	localparam int POS_PROX_TWO_ON     = 1;
	localparam int POS_PROX_THREE_ON   = 2;
	localparam int POS_AMB_VISIBLE_ON  = 4;
	localparam int POS_AMB_INFRARED_ON = 5;
	localparam int POS_AUX_ON          = 6;
	localparam int POS_PROX_ONE_LED    = 0;
	localparam int POS_PROX_TWO_LED    = 4;
	localparam int POS_PROX_THREE_LED  = 0;
	localparam int POS_PROX_ONE_LOW    = 4;
	localparam int POS_PROX_TWO_LOW    = 5;
	localparam int POS_PROX_THREE_LOW  = 6;

	localparam int CONV_W = 17;
	localparam int RES_W  = 16;

	typedef enum logic [1:0] {
		SPT_CMD_NONE   = 2'b00,
		SPT_CMD_READ   = 2'b01,
		SPT_CMD_WRITE  = 2'b10,
		SPT_CMD_BUSADR = 2'b11
	} spt_cmd_t;

	// command request from the command decoder
	typedef struct packed {
		spt_cmd_t   cmd;
		logic [7:0] ofs;
		logic [7:0] data;
	} spt_req_t;

	// per-channel settings handed to the sequencer
	typedef struct packed {
		logic       on;
		logic [2:0] led;
		logic       low_bits;
	} spt_prox_cfg_t;
endpackage : spt_pkg

// ==== rtl/spt_align.sv ====
`timescale 1ns/1ps
module spt_align (
	// conversion in
	input  wire logic [16:0] i_conv,
	input  wire logic        i_low_bits,
	// result out
	output logic      [15:0] o_result
);
	// 17-bit conversion squeezed into 16 bits
	assign o_result = i_low_bits ? i_conv[15:0] : i_conv[16:1];
endmodule : spt_align

// ==== rtl/spt_param_table.sv ====
`timescale 1ns/1ps
// Behaviour
// - new address applies only on address-change command
// - bit 6 runs auxiliary channel
// - bit 5 runs ambient infrared channel
// - bit 4 runs ambient visible channel
// - bits 0-2 enable proximity one to three
// - channel one LED field bits 2:0
// - channel two LED field bits 6:4
// - channel three LED field separate, bits 2:0
// - shared LED select resets to 0x21
// - channel three LED select resets to 0x04
// - 16-bit result, upper or lower bits
// - alignment bits 6,5,4 cleared at reset
// - parameters reached only via query/set commands
module spt_param_table (
	// clock and reset
	input  wire logic                   i_core_clk,
	input  wire logic                   i_rst_b,
	// command port
	input  wire spt_pkg::spt_req_t      i_req,
	output logic                        o_rd_valid,
	output logic [7:0]                  o_rd_data,
	// bus address in use
	output logic [6:0]                  o_bus_address,
	// sequencer view
	output logic                        o_aux_on,
	output logic                        o_amb_infrared_on,
	output logic                        o_amb_visible_on,
	output spt_pkg::spt_prox_cfg_t      o_prox_one,
	output spt_pkg::spt_prox_cfg_t      o_prox_two,
	output spt_pkg::spt_prox_cfg_t      o_prox_three,
	output logic [7:0]                  o_amb_history,
	output logic [7:0]                  o_conv_offset,
	output logic [7:0]                  o_led_recovery,
	output logic [7:0]                  o_ir_conv_counter,
	output logic [7:0]                  o_ir_conv_gain,
	output logic [7:0]                  o_ir_conv_misc,
	// proximity conversions
	input  wire logic                   i_prox_done,
	input  wire logic [1:0]             i_prox_chan,
	input  wire logic [16:0]            i_prox_conv,
	output logic [15:0]                 o_prox_one_result,
	output logic [15:0]                 o_prox_two_result,
	output logic [15:0]                 o_prox_three_result,
	output logic                        o_no_channel
);
	logic [7:0]  new_bus_address_r;
	logic [7:0]  channel_enable_list_r;
	logic [7:0]  led_select_ch1_ch2_r;
	logic [7:0]  led_select_ch3_r;
	logic [7:0]  proximity_result_alignment_r;
	logic [7:0]  amb_history_r;
	logic [7:0]  conv_offset_r;
	logic [7:0]  led_recovery_r;
	logic [7:0]  ir_counter_r;
	logic [7:0]  ir_gain_r;
	logic [7:0]  ir_misc_r;
	logic [6:0]  bus_address_r;
	logic [15:0] aligned;
	logic        sel_low;
	logic        wr;
	logic [7:0]  rd_nxt;

	function automatic logic hit(input logic [7:0] ofs);
		hit = wr && (i_req.ofs == ofs);
	endfunction : hit

	// only the query/set path reaches the table, no direct bus map
	assign wr = (i_req.cmd == spt_pkg::SPT_CMD_WRITE);

	always_ff @(posedge i_core_clk or negedge i_rst_b) begin
		if (!i_rst_b) begin
			new_bus_address_r <= spt_pkg::RST_NEW_BUS_ADDRESS;
		end else if (hit(spt_pkg::OFS_NEW_BUS_ADDRESS)) begin
			new_bus_address_r <= i_req.data;
		end
	end

	// stored address waits for the change command; 7-bit bus uses low bits
	always_ff @(posedge i_core_clk or negedge i_rst_b) begin
		if (!i_rst_b) begin
			bus_address_r <= spt_pkg::RST_BUS_ADDRESS;
		end else if (i_req.cmd == spt_pkg::SPT_CMD_BUSADR) begin
			bus_address_r <= new_bus_address_r[6:0];
		end
	end

	// reserved bits masked off so they never reach the sequencer
	always_ff @(posedge i_core_clk or negedge i_rst_b) begin
		if (!i_rst_b) begin
			channel_enable_list_r <= spt_pkg::RST_CHANNEL_ENABLE;
		end else if (hit(spt_pkg::OFS_CHANNEL_ENABLE)) begin
			channel_enable_list_r <= i_req.data & spt_pkg::MSK_CHANNEL_ENABLE;
		end
	end

	always_ff @(posedge i_core_clk or negedge i_rst_b) begin
		if (!i_rst_b) begin
			led_select_ch1_ch2_r <= spt_pkg::RST_LED_SEL_CH1_CH2;
			led_select_ch3_r     <= spt_pkg::RST_LED_SEL_CH3;
		end else begin
			if (hit(spt_pkg::OFS_LED_SEL_CH1_CH2)) begin
				led_select_ch1_ch2_r <= i_req.data & spt_pkg::MSK_LED_SEL_CH1_CH2;
			end
			if (hit(spt_pkg::OFS_LED_SEL_CH3)) begin
				led_select_ch3_r <= i_req.data & spt_pkg::MSK_LED_SEL_CH3;
			end
		end
	end

	always_ff @(posedge i_core_clk or negedge i_rst_b) begin
		if (!i_rst_b) begin
			proximity_result_alignment_r <= spt_pkg::RST_PROX_ALIGNMENT;
		end else if (hit(spt_pkg::OFS_PROX_ALIGNMENT)) begin
			proximity_result_alignment_r <= i_req.data & spt_pkg::MSK_PROX_ALIGNMENT;
		end
	end

	// upper map; reset values not given, zero chosen
	always_ff @(posedge i_core_clk or negedge i_rst_b) begin
		if (!i_rst_b) begin
			amb_history_r  <= spt_pkg::RST_OTHER;
			conv_offset_r  <= spt_pkg::RST_OTHER;
			led_recovery_r <= spt_pkg::RST_OTHER;
			ir_counter_r   <= spt_pkg::RST_OTHER;
			ir_gain_r      <= spt_pkg::RST_OTHER;
			ir_misc_r      <= spt_pkg::RST_OTHER;
		end else begin
			if (hit(spt_pkg::OFS_AMB_HISTORY)) begin
				amb_history_r <= i_req.data;
			end
			if (hit(spt_pkg::OFS_CONV_OFFSET)) begin
				conv_offset_r <= i_req.data;
			end
			if (hit(spt_pkg::OFS_LED_RECOVERY)) begin
				led_recovery_r <= i_req.data;
			end
			if (hit(spt_pkg::OFS_IR_CONV_COUNTER)) begin
				ir_counter_r <= i_req.data & spt_pkg::MSK_IR_CONV_COUNTER;
			end
			if (hit(spt_pkg::OFS_IR_CONV_GAIN)) begin
				ir_gain_r <= i_req.data;
			end
			if (hit(spt_pkg::OFS_IR_CONV_MISC)) begin
				ir_misc_r <= i_req.data;
			end
		end
	end
	// offset 0x1B has no storage: host keeps it at zero, reads return zero

	always_comb begin
		case (i_req.ofs)
			spt_pkg::OFS_NEW_BUS_ADDRESS: rd_nxt = new_bus_address_r;
			spt_pkg::OFS_CHANNEL_ENABLE:  rd_nxt = channel_enable_list_r;
			spt_pkg::OFS_LED_SEL_CH1_CH2: rd_nxt = led_select_ch1_ch2_r;
			spt_pkg::OFS_LED_SEL_CH3:     rd_nxt = led_select_ch3_r;
			spt_pkg::OFS_PROX_ALIGNMENT:  rd_nxt = proximity_result_alignment_r;
			spt_pkg::OFS_AMB_HISTORY:     rd_nxt = amb_history_r;
			spt_pkg::OFS_CONV_OFFSET:     rd_nxt = conv_offset_r;
			spt_pkg::OFS_LED_RECOVERY:    rd_nxt = led_recovery_r;
			spt_pkg::OFS_IR_CONV_COUNTER: rd_nxt = ir_counter_r;
			spt_pkg::OFS_IR_CONV_GAIN:    rd_nxt = ir_gain_r;
			spt_pkg::OFS_IR_CONV_MISC:    rd_nxt = ir_misc_r;
			default:                      rd_nxt = 8'h00;
		endcase
	end

	always_ff @(posedge i_core_clk or negedge i_rst_b) begin
		if (!i_rst_b) begin
			o_rd_valid <= 1'b0;
			o_rd_data  <= 8'h00;
		end else begin
			o_rd_valid <= (i_req.cmd == spt_pkg::SPT_CMD_READ);
			if (i_req.cmd == spt_pkg::SPT_CMD_READ) begin
				o_rd_data <= rd_nxt;
			end
		end
	end

	// registered sequencer view, one cycle after the table
	always_ff @(posedge i_core_clk or negedge i_rst_b) begin
		if (!i_rst_b) begin
			o_aux_on          <= 1'b0;
			o_amb_infrared_on <= 1'b0;
			o_amb_visible_on  <= 1'b0;
			o_prox_one        <= '0;
			o_prox_two        <= '0;
			o_prox_three      <= '0;
			o_no_channel      <= 1'b1;
		end else begin
			o_aux_on          <= channel_enable_list_r[spt_pkg::POS_AUX_ON];
			o_amb_infrared_on <= channel_enable_list_r[spt_pkg::POS_AMB_INFRARED_ON];
			o_amb_visible_on  <= channel_enable_list_r[spt_pkg::POS_AMB_VISIBLE_ON];
			o_prox_one.on     <= channel_enable_list_r[spt_pkg::POS_PROX_ONE_ON];
			o_prox_two.on     <= channel_enable_list_r[spt_pkg::POS_PROX_TWO_ON];
			o_prox_three.on   <= channel_enable_list_r[spt_pkg::POS_PROX_THREE_ON];
			o_prox_one.led    <= led_select_ch1_ch2_r[spt_pkg::POS_PROX_ONE_LED +: 3];
			o_prox_two.led    <= led_select_ch1_ch2_r[spt_pkg::POS_PROX_TWO_LED +: 3];
			o_prox_three.led  <= led_select_ch3_r[spt_pkg::POS_PROX_THREE_LED +: 3];
			o_prox_one.low_bits   <= proximity_result_alignment_r[spt_pkg::POS_PROX_ONE_LOW];
			o_prox_two.low_bits   <= proximity_result_alignment_r[spt_pkg::POS_PROX_TWO_LOW];
			o_prox_three.low_bits <= proximity_result_alignment_r[spt_pkg::POS_PROX_THREE_LOW];
			// flag only; the sequencer relies on the host having set a channel
			o_no_channel      <= (channel_enable_list_r == 8'h00);
		end
	end

	always_ff @(posedge i_core_clk or negedge i_rst_b) begin
		if (!i_rst_b) begin
			o_bus_address     <= spt_pkg::RST_BUS_ADDRESS;
			o_amb_history     <= 8'h00;
			o_conv_offset     <= 8'h00;
			o_led_recovery    <= 8'h00;
			o_ir_conv_counter <= 8'h00;
			o_ir_conv_gain    <= 8'h00;
			o_ir_conv_misc    <= 8'h00;
		end else begin
			o_bus_address     <= bus_address_r;
			o_amb_history     <= amb_history_r;
			o_conv_offset     <= conv_offset_r;
			o_led_recovery    <= led_recovery_r;
			o_ir_conv_counter <= ir_counter_r;
			o_ir_conv_gain    <= ir_gain_r;
			o_ir_conv_misc    <= ir_misc_r;
		end
	end

	always_comb begin
		case (i_prox_chan)
			2'h1:    sel_low = proximity_result_alignment_r[spt_pkg::POS_PROX_TWO_LOW];
			2'h2:    sel_low = proximity_result_alignment_r[spt_pkg::POS_PROX_THREE_LOW];
			default: sel_low = proximity_result_alignment_r[spt_pkg::POS_PROX_ONE_LOW];
		endcase
	end

	spt_align u_align (
		.i_conv     (i_prox_conv),
		.i_low_bits (sel_low),
		.o_result   (aligned)
	);

	// each result lands only in its own channel's pair, and only if enabled
	always_ff @(posedge i_core_clk or negedge i_rst_b) begin
		if (!i_rst_b) begin
			o_prox_one_result   <= 16'h0000;
			o_prox_two_result   <= 16'h0000;
			o_prox_three_result <= 16'h0000;
		end else if (i_prox_done) begin
			if (i_prox_chan == 2'h0 && channel_enable_list_r[spt_pkg::POS_PROX_ONE_ON]) begin
				o_prox_one_result <= aligned;
			end
			if (i_prox_chan == 2'h1 && channel_enable_list_r[spt_pkg::POS_PROX_TWO_ON]) begin
				o_prox_two_result <= aligned;
			end
			if (i_prox_chan == 2'h2 && channel_enable_list_r[spt_pkg::POS_PROX_THREE_ON]) begin
				o_prox_three_result <= aligned;
			end
		end
	end

	bus_address_change_cmd_held_a: assert property (@(posedge i_core_clk) disable iff (!i_rst_b)
		(i_req.cmd != spt_pkg::SPT_CMD_BUSADR) |=> $stable(bus_address_r))
		else $error("bus address changed without command");
	bus_address_change_cmd_take_a: assert property (@(posedge i_core_clk) disable iff (!i_rst_b)
		(i_req.cmd == spt_pkg::SPT_CMD_BUSADR) |-> ##2 (o_bus_address == $past(new_bus_address_r[6:0], 2)))
		else $error("bus address not taken");
	aux_on_a: assert property (@(posedge i_core_clk) disable iff (!i_rst_b)
		##1 (o_aux_on == $past(channel_enable_list_r[6])))
		else $error("aux enable wrong");
	amb_ir_a: assert property (@(posedge i_core_clk) disable iff (!i_rst_b)
		hit(spt_pkg::OFS_CHANNEL_ENABLE) |-> ##2 (o_amb_infrared_on == $past(i_req.data[5], 2)))
		else $error("infrared enable wrong");
	amb_vis_a: assert property (@(posedge i_core_clk) disable iff (!i_rst_b)
		hit(spt_pkg::OFS_CHANNEL_ENABLE) |-> ##2 (o_amb_visible_on == $past(i_req.data[4], 2)))
		else $error("visible enable wrong");
	prox_en_a: assert property (@(posedge i_core_clk) disable iff (!i_rst_b)
		hit(spt_pkg::OFS_CHANNEL_ENABLE) |-> ##2
		({o_prox_three.on, o_prox_two.on, o_prox_one.on} == $past(i_req.data[2:0], 2)))
		else $error("proximity enable wrong");
	led_two_a: assert property (@(posedge i_core_clk) disable iff (!i_rst_b)
		hit(spt_pkg::OFS_LED_SEL_CH1_CH2) |-> ##2
		(o_prox_two.led == $past(i_req.data[6:4], 2) && o_prox_one.led == $past(i_req.data[2:0], 2)))
		else $error("led select wrong");
	led_three_a: assert property (@(posedge i_core_clk) disable iff (!i_rst_b)
		hit(spt_pkg::OFS_LED_SEL_CH3) |-> ##2 (o_prox_three.led == $past(i_req.data[2:0], 2)))
		else $error("channel three led wrong");
	align_res_a: assert property (@(posedge i_core_clk) disable iff (!i_rst_b)
		(i_prox_done && i_prox_chan == 2'h0 && channel_enable_list_r[0]) |=>
		(o_prox_one_result == ($past(proximity_result_alignment_r[4]) ?
		$past(i_prox_conv[15:0]) : $past(i_prox_conv[16:1]))))
		else $error("result alignment wrong");
	rsvd_zero_a: assert property (@(posedge i_core_clk) disable iff (!i_rst_b)
		(i_req.cmd == spt_pkg::SPT_CMD_READ && i_req.ofs == spt_pkg::OFS_RESERVED_1B) |=> (o_rd_data == 8'h00))
		else $error("reserved read not zero");
endmodule : spt_param_table

// ==== verification/spt_host_model.sv ====
`timescale 1ns/1ps
module spt_host_model (
	// clock
	input  wire logic         i_core_clk,
	// read answer
	input  wire logic         i_rd_valid,
	input  wire logic [7:0]   i_rd_data,
	// command and conversion drive
	output spt_pkg::spt_req_t o_req,
	output logic              o_prox_done,
	output logic [1:0]        o_prox_chan,
	output logic [16:0]       o_prox_conv
);
	initial begin
		o_req       = '{cmd: spt_pkg::SPT_CMD_NONE, ofs: 8'h00, data: 8'h00};
		o_prox_done = 1'b0;
		o_prox_chan = 2'h3;
		o_prox_conv = 17'h00000;
	end

	// one-cycle command, parameters only via query/set
	// idle fields flip so stale values never pass for live ones
	task automatic put(input spt_pkg::spt_cmd_t cmd, input logic [7:0] ofs, input logic [7:0] data);
		@(negedge i_core_clk);
		o_req = '{cmd: cmd, ofs: ofs, data: data};
		@(negedge i_core_clk);
		o_req = '{cmd: spt_pkg::SPT_CMD_NONE, ofs: ~ofs, data: ~data};
	endtask : put

	// query, answer awaited for a bounded time only
	task automatic rd(input logic [7:0] ofs, output logic [7:0] data, output logic ok);
		ok   = 1'b0;
		data = 8'h00;
		put(spt_pkg::SPT_CMD_READ, ofs, 8'h00);
		for (int k = 0; k < 3 && !ok; k++) begin
			if (i_rd_valid === 1'b1) begin
				ok   = 1'b1;
				data = i_rd_data;
			end else begin
				@(negedge i_core_clk);
			end
		end
	endtask : rd

	// finished conversion for one proximity channel
	task automatic conv(input logic [1:0] chan, input logic [16:0] value);
		@(negedge i_core_clk);
		o_prox_done = 1'b1;
		o_prox_chan = chan;
		o_prox_conv = value;
		@(negedge i_core_clk);
		o_prox_done = 1'b0;
		o_prox_chan = ~chan;
		o_prox_conv = ~value;
	endtask : conv
endmodule : spt_host_model

// ==== verification/testbench.sv ====
`timescale 1ns/1ps
module testbench;
	logic                   i_core_clk;
	logic                   i_rst_b;
	spt_pkg::spt_req_t      req;
	logic                   rd_valid, done, aux_on, ir_on, vis_on, no_chan;
	logic [7:0]             rd_data;
	logic [6:0]             bus_address;
	logic [1:0]             chan;
	logic [16:0]            conv;
	logic [15:0]            res1, res2, res3;
	logic [7:0]             hist, cofs, lrec, ircnt, irgain, irmisc;
	spt_pkg::spt_prox_cfg_t p1, p2, p3;
	int                     err_total = 0;
	int                     n_checks = 0;
	typedef struct packed {logic [7:0] ofs; logic [7:0] wr; logic [7:0] rd;} spt_row_t;
	// reserved bits and unmapped offsets must come back zero
	// encoding and 0x1B rows keep the host-reserved positions at zero
	spt_row_t rows [12] = '{'{8'h00, 8'h33, 8'h33}, '{8'h01, 8'hFF, 8'h77}, '{8'h02, 8'hFF, 8'h77},
		'{8'h03, 8'hFF, 8'h07}, '{8'h05, 8'h70, 8'h70}, '{8'h19, 8'hA5, 8'hA5}, '{8'h1A, 8'h5A, 8'h5A},
		'{8'h1B, 8'h00, 8'h00}, '{8'h1C, 8'hC3, 8'hC3}, '{8'h1D, 8'hFF, 8'h70}, '{8'h1E, 8'h3C, 8'h3C},
		'{8'h04, 8'hAA, 8'h00}};
	spt_row_t rst_rows [5] = '{'{8'h00, 8'h00, 8'h00}, '{8'h01, 8'h00, 8'h00}, '{8'h02, 8'h00, 8'h21},
		'{8'h03, 8'h00, 8'h04}, '{8'h05, 8'h00, 8'h00}};
	logic [16:0] v = 17'h1ABCD;

	spt_param_table DUT (.i_core_clk(i_core_clk), .i_rst_b(i_rst_b), .i_req(req), .o_rd_valid(rd_valid),
		.o_rd_data(rd_data), .o_bus_address(bus_address), .o_aux_on(aux_on), .o_amb_infrared_on(ir_on),
		.o_amb_visible_on(vis_on), .o_prox_one(p1), .o_prox_two(p2), .o_prox_three(p3), .o_amb_history(hist),
		.o_conv_offset(cofs), .o_led_recovery(lrec), .o_ir_conv_counter(ircnt), .o_ir_conv_gain(irgain),
		.o_ir_conv_misc(irmisc),
		.i_prox_done(done), .i_prox_chan(chan), .i_prox_conv(conv), .o_prox_one_result(res1),
		.o_prox_two_result(res2), .o_prox_three_result(res3), .o_no_channel(no_chan));
	spt_host_model u_host (.i_core_clk(i_core_clk), .i_rd_valid(rd_valid), .i_rd_data(rd_data), .o_req(req),
		.o_prox_done(done), .o_prox_chan(chan), .o_prox_conv(conv));

	initial begin
		i_core_clk = 1'b0;
		forever #50 i_core_clk = ~i_core_clk;
	end

	task automatic end_of_test;
		$display("checks %0d errors %0d", n_checks, err_total);
		if (err_total == 0 && n_checks > 0) begin
			$display("SIMULATION PASSED");
		end else begin
			$display("SIMULATION FAILED");
		end
		$finish;
	endtask : end_of_test

	task automatic chk(input string name, input logic [31:0] seen, input logic [31:0] exp);
		n_checks++;
		if (seen !== exp) begin
			err_total++;
			$display("ERROR %s expected %0h seen %0h", name, exp, seen);
		end
	endtask : chk

	task automatic rdc(input string name, input logic [7:0] ofs, input logic [7:0] exp);
		logic [7:0] d;
		logic       ok;
		u_host.rd(ofs, d, ok);
		if (ok !== 1'b1) begin
			err_total++;
			$display("ERROR %s no read answer", name);
			end_of_test();
		end else begin
			chk(name, 32'(d), 32'(exp));
		end
	endtask : rdc

	task automatic wr(input logic [7:0] ofs, input logic [7:0] data);
		u_host.put(spt_pkg::SPT_CMD_WRITE, ofs, data);
		repeat (3) @(negedge i_core_clk);
	endtask : wr

	task automatic chk_reset;
		// sequencer view is loaded from the table one edge after release
		@(negedge i_core_clk);
		chk("bus_address", 32'(bus_address), 32'(spt_pkg::RST_BUS_ADDRESS));
		chk("leds", {p3.led, p2.led, p1.led}, {3'b100, 3'b010, 3'b001});
		chk("low_bits", {p3.low_bits, p2.low_bits, p1.low_bits}, 3'b000);
		chk("no_channel", 32'(no_chan), 1);
		foreach (rst_rows[k]) rdc("reset_value", rst_rows[k].ofs, rst_rows[k].rd);
	endtask : chk_reset

	initial begin
		i_rst_b = 1'b0;
		repeat (2) @(negedge i_core_clk);
		i_rst_b = 1'b1;
		chk_reset();
		foreach (rows[k]) begin
			u_host.put(spt_pkg::SPT_CMD_WRITE, rows[k].ofs, rows[k].wr);
			rdc("readback", rows[k].ofs, rows[k].rd);
		end
		// stored address must not be used until the change command
		chk("bus_address_held", 32'(bus_address), 32'(spt_pkg::RST_BUS_ADDRESS));
		// values set through the set command reach the sequencer copies; ir_conv_misc is never set and stays at zero
		chk("amb_history", 32'(hist), 32'hA5);
		chk("conv_offset", 32'(cofs), 32'h5A);
		chk("led_recovery", 32'(lrec), 32'hC3);
		chk("ir_conv_counter", 32'(ircnt), 32'h70);
		chk("ir_conv_gain", 32'(irgain), 32'h3C);
		chk("ir_conv_misc", 32'(irmisc), 32'h00);
		u_host.put(spt_pkg::SPT_CMD_BUSADR, 8'h00, 8'h00);
		repeat (3) @(negedge i_core_clk);
		chk("bus_address_new", 32'(bus_address), 7'h33);
		wr(8'h02, 8'h35);
		wr(8'h03, 8'h02);
		chk("led_sel", {p3.led, p2.led, p1.led}, {3'b010, 3'b011, 3'b101});
		wr(8'h05, 8'h50);
		chk("low_sel", {p3.low_bits, p2.low_bits, p1.low_bits}, 3'b101);
		for (int i = 0; i < 7; i++) begin
			if (i != 3) begin
				wr(8'h01, 8'(8'h01 << i));
				chk("chan_on", {aux_on, ir_on, vis_on, 1'b0, p3.on, p2.on, p1.on}, 8'h01 << i);
				chk("no_channel_low", 32'(no_chan), 0);
			end
		end
		wr(8'h01, 8'h07);
		for (int c = 0; c < 3; c++) u_host.conv(2'(c), v);
		@(negedge i_core_clk);
		chk("result_one", 32'(res1), 32'(v[15:0]));
		chk("result_two", 32'(res2), 32'(v[16:1]));
		chk("result_three", 32'(res3), 32'(v[15:0]));
		wr(8'h01, 8'h01);
		u_host.conv(2'h1, 17'h00F0F);
		u_host.conv(2'h3, 17'h00F0F);
		@(negedge i_core_clk);
		chk("disabled_one", 32'(res1), 32'(v[15:0]));
		chk("disabled_two", 32'(res2), 32'(v[16:1]));
		chk("disabled_three", 32'(res3), 32'(v[15:0]));
		wr(8'h01, 8'h00);
		chk("no_channel_back", 32'(no_chan), 1);
		// second reset mid-run restores every table value
		i_rst_b = 1'b0;
		@(negedge i_core_clk);
		i_rst_b = 1'b1;
		chk_reset();
		end_of_test();
	end
endmodule : testbench
